// ---- design/exec_subset_pkg.sv ----
// Summary of operation
// - The store instruction copies the working register into the addressed file register in one cycle, touching no flag.
// - Return from interrupt pops the stack top into the program counter, sets the global interrupt enable at bit 7 and takes two cycles.
// - The legacy prescaler load copies the working register into the prescaler configuration register in one cycle with no flag change.
// - Return with literal loads the 8-bit literal into the working register, pops the stack top into the program counter and takes two cycles.
// - Subroutine return pops the stack top into the program counter in two cycles and leaves the flags alone.
// - Rotate right moves the old carry into bit 7 and bit 0 into the carry, changing only carry.
// - Rotate left moves the old carry into bit 0 and bit 7 into the carry, changing only carry.
// - A destination bit of 0 sends the result to the working register and 1 sends it back to the addressed file register.
// - Sleep clears the watchdog counter and prescaler, clears the power-down flag, sets the time-out flag and halts with the oscillator stopped.
// - Subtract from literal puts the literal minus the working register into the working register and updates carry, digit carry and zero.
// - After a subtraction carry is 1 for a positive or zero result and 0 for a negative one.
// - Subtract from file computes the register minus the working register, routes it by the destination bit and updates carry, digit carry and zero.
// - The legacy direction load copies the working register into the direction register chosen by operand 5 to 7.
`default_nettype none
package exec_subset_pkg;
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 13;
   localparam int NUM_DIR = 3;
   // Opcode prefixes, matched on the top bits of the instruction word.
   localparam logic [6:0] OP_STORE = 7'h01;
   localparam logic [5:0] OP_SUB_FILE = 6'h02;
   localparam logic [5:0] OP_XOR_FILE = 6'h06;
   localparam logic [5:0] OP_ROT_RIGHT = 6'h0C;
   localparam logic [5:0] OP_ROT_LEFT = 6'h0D;
   localparam logic [5:0] OP_SWAP = 6'h0E;
   localparam logic [3:0] OP_RET_LIT = 4'hD;
   localparam logic [4:0] OP_SUB_LIT = 5'h1E;
   localparam logic [5:0] OP_XOR_LIT = 6'h3A;
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_RET_IRQ = 14'h0009;
   localparam logic [13:0] OP_OPTION = 14'h0062;
   localparam logic [13:0] OP_SLEEP = 14'h0063;
   localparam logic [10:0] OP_DIR_LOAD = 11'h00C;
   localparam logic [13:0] NOP_MASK = 14'h3F9F;
   localparam logic [13:0] OP_NOP = 14'h0000;
   localparam logic [2:0] DIR_FIRST = 3'h5;
   localparam logic [2:0] DIR_LAST = 3'h7;
   localparam int IRQ_ENABLE_BIT = 7;
   // Reset values.
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_INTCTL = 8'h00;
   localparam logic [7:0] RST_W = 8'h00;

   typedef struct packed {
      logic we;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } file_wr_s;

   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
      logic zero;
   } alu_flags_s;

   typedef enum logic [1:0] {ST_EXEC, ST_RET_WAIT, ST_SLEEP} exec_state_e;
endpackage
`default_nettype wire

// ---- design/exec_subset.sv ----
`timescale 1ns/1ns
`default_nettype none
module exec_subset (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // Instruction fetch handshake.
   input wire logic i_instr_valid,
   input wire logic [exec_subset_pkg::INSTR_W-1:0] i_instr,
   output logic o_instr_ready,
   // Data file: combinational read, registered write.
   output logic [exec_subset_pkg::FADDR_W-1:0] o_file_raddr,
   input wire logic [exec_subset_pkg::DATA_W-1:0] i_file_rdata,
   output exec_subset_pkg::file_wr_s o_file_wr,
   // Stack and program counter.
   input wire logic [exec_subset_pkg::PC_W-1:0] i_stack_top,
   output logic o_stack_pop,
   output logic o_pc_load,
   output logic [exec_subset_pkg::PC_W-1:0] o_pc_value,
   output logic o_pc_advance,
   // Processor state.
   output logic [exec_subset_pkg::DATA_W-1:0] o_working,
   output exec_subset_pkg::alu_flags_s o_flags,
   output logic [exec_subset_pkg::DATA_W-1:0] o_interrupt_control_reg,
   output logic [exec_subset_pkg::DATA_W-1:0] o_prescaler_cfg,
   output logic [exec_subset_pkg::NUM_DIR*exec_subset_pkg::DATA_W-1:0] o_pin_direction_register,
   // Power management.
   output logic o_watchdog_clear,
   output logic o_timeout_flag,
   output logic o_powerdown_flag,
   output logic o_sleeping,
   input wire logic i_wake,
   output logic o_unsupported
);
   import exec_subset_pkg::*;

   // ==========================================================
   // Decode
   // ==========================================================
   wire logic [13:0] ins = i_instr;
   wire logic take = i_instr_valid && o_instr_ready;
   wire logic dest_file = ins[7];
   wire logic [7:0] lit = ins[7:0];
   wire logic is_store = ins[13:7] == OP_STORE;
   wire logic is_sub_file = ins[13:8] == OP_SUB_FILE;
   wire logic is_xor_file = ins[13:8] == OP_XOR_FILE;
   wire logic is_rot_right = ins[13:8] == OP_ROT_RIGHT;
   wire logic is_rot_left = ins[13:8] == OP_ROT_LEFT;
   wire logic is_swap = ins[13:8] == OP_SWAP;
   wire logic is_ret_lit = ins[13:10] == OP_RET_LIT;
   wire logic is_sub_lit = ins[13:9] == OP_SUB_LIT;
   wire logic is_xor_lit = ins[13:8] == OP_XOR_LIT;
   wire logic is_return = ins == OP_RETURN;
   wire logic is_ret_irq = ins == OP_RET_IRQ;
   wire logic is_option = ins == OP_OPTION;
   wire logic is_sleep = ins == OP_SLEEP;
   wire logic is_dir_load = ins[13:3] == OP_DIR_LOAD;
   wire logic dir_load_ok = is_dir_load && ins[2:0] >= DIR_FIRST && ins[2:0] <= DIR_LAST;
   // Operands 5 to 7 map onto slots 0 to 2; the cut to two bits is deliberate.
   wire logic [1:0] dir_idx = 2'(ins[2:0] - DIR_FIRST);
   wire logic is_nop = (ins & NOP_MASK) == OP_NOP;
   wire logic is_pop = is_return || is_ret_irq || is_ret_lit;
   wire logic is_fileop = is_sub_file || is_xor_file || is_rot_right || is_rot_left || is_swap;
   wire logic known = is_store || is_fileop || is_ret_lit || is_sub_lit || is_xor_lit
                      || is_pop || is_option || is_sleep || is_dir_load || is_nop;

   // ==========================================================
   // Arithmetic
   // ==========================================================
   logic [7:0] w_ff;
   alu_flags_s flags_ff;
   wire logic [7:0] freg = i_file_rdata;
   // Both subtractions share one adder; the minuend is the literal or the register.
   wire logic [7:0] minuend = is_sub_lit ? lit : freg;
   wire logic [8:0] diff = {1'b0, minuend} + {1'b0, ~w_ff} + 9'h001;
   wire logic [4:0] diff_lo = {1'b0, minuend[3:0]} + {1'b0, ~w_ff[3:0]} + 5'h01;
   wire logic [7:0] rot_right_res = {flags_ff.carry, freg[7:1]};
   wire logic [7:0] rot_left_res = {freg[6:0], flags_ff.carry};
   wire logic [7:0] swap_res = {freg[3:0], freg[7:4]};
   wire logic [7:0] xor_res = w_ff ^ (is_xor_lit ? lit : freg);
   wire logic [7:0] result = (is_sub_file || is_sub_lit) ? diff[7:0] :
                             is_rot_right ? rot_right_res :
                             is_rot_left ? rot_left_res :
                             is_swap ? swap_res : xor_res;
   wire logic is_sub = is_sub_file || is_sub_lit;
   wire logic is_xor = is_xor_file || is_xor_lit;
   // Literal operations always land in the working register.
   wire logic to_file = (is_fileop && dest_file) || is_store;
   wire logic to_w = (is_fileop && !dest_file) || is_sub_lit || is_xor_lit || is_ret_lit;

   // ==========================================================
   // State
   // ==========================================================
   exec_state_e state_ff, nxt_state;
   logic [7:0] intctl_ff, option_ff;
   logic [7:0] dir_ff [NUM_DIR];
   logic timeout_ff, powerdown_ff;
   file_wr_s wr_ff;
   logic pop_ff, pc_adv_ff, wd_clr_ff, unsup_ff;
   logic [PC_W-1:0] pc_ff;

   assign o_instr_ready = state_ff == ST_EXEC;
   assign o_file_raddr = ins[6:0];

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_EXEC: begin
            if (take && is_pop) begin
               nxt_state = ST_RET_WAIT;
            end else if (take && is_sleep) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_RET_WAIT: nxt_state = ST_EXEC;
         ST_SLEEP: begin
            if (i_wake) begin
               nxt_state = ST_EXEC;
            end
         end
         default: nxt_state = ST_EXEC;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= ST_EXEC;
         w_ff <= RST_W;
         flags_ff <= '0;
         intctl_ff <= RST_INTCTL;
         option_ff <= RST_OPTION;
         for (int i = 0; i < NUM_DIR; i++) begin
            dir_ff[i] <= RST_DIR;
         end
         timeout_ff <= 1'b1;
         powerdown_ff <= 1'b1;
         wr_ff <= '0;
         pop_ff <= 1'b0;
         pc_adv_ff <= 1'b0;
         wd_clr_ff <= 1'b0;
         unsup_ff <= 1'b0;
         pc_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         wr_ff.we <= take && to_file;
         wr_ff.addr <= ins[6:0];
         wr_ff.data <= is_store ? w_ff : result;
         pop_ff <= take && is_pop;
         pc_ff <= i_stack_top;
         // Returns load the counter instead and sleep leaves it; every other taken word advances it.
         pc_adv_ff <= take && !is_pop && !is_sleep;
         wd_clr_ff <= take && is_sleep;
         unsup_ff <= take && !known;
         if (take && to_w) begin
            w_ff <= is_ret_lit ? lit : result;
         end
         if (take && is_sub) begin
            flags_ff.carry <= diff[8];
            flags_ff.digit_carry_flag <= diff_lo[4];
            flags_ff.zero <= diff[7:0] == 8'h00;
         end else if (take && (is_rot_right || is_rot_left)) begin
            flags_ff.carry <= is_rot_right ? freg[0] : freg[7];
         end else if (take && is_xor) begin
            flags_ff.zero <= xor_res == 8'h00;
         end
         if (take && is_ret_irq) begin
            intctl_ff[IRQ_ENABLE_BIT] <= 1'b1;
         end
         if (take && is_option) begin
            option_ff <= w_ff;
         end
         if (take && dir_load_ok) begin
            dir_ff[dir_idx] <= w_ff;
         end
         if (take && is_sleep) begin
            timeout_ff <= 1'b1;
            powerdown_ff <= 1'b0;
         end
      end
   end

   assign o_file_wr = wr_ff;
   assign o_stack_pop = pop_ff;
   assign o_pc_load = pop_ff;
   assign o_pc_value = pc_ff;
   assign o_pc_advance = pc_adv_ff;
   assign o_working = w_ff;
   assign o_flags = flags_ff;
   assign o_interrupt_control_reg = intctl_ff;
   assign o_prescaler_cfg = option_ff;
   for (genvar g = 0; g < NUM_DIR; g++) begin : g_dir
      assign o_pin_direction_register[g*DATA_W +: DATA_W] = dir_ff[g];
   end
   assign o_watchdog_clear = wd_clr_ff;
   assign o_timeout_flag = timeout_ff;
   assign o_powerdown_flag = powerdown_ff;
   // The clock keeps running here; the outer logic stops the oscillator on this level.
   assign o_sleeping = state_ff == ST_SLEEP;
   assign o_unsupported = unsup_ff;

   // ==========================================================
   // Checks
   // ==========================================================
   store_copies_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_store |=> o_file_wr.we && o_file_wr.data == $past(w_ff)
         && o_flags == $past(flags_ff))
      else $error("store did not copy working register");
   irq_return_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_ret_irq |=> o_interrupt_control_reg[IRQ_ENABLE_BIT] && o_pc_load
         && !o_instr_ready ##1 o_instr_ready)
      else $error("interrupt return wrong");
   option_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_option |=> o_prescaler_cfg == $past(w_ff))
      else $error("prescaler load wrong");
   lit_return_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_ret_lit |=> o_working == $past(lit) && o_pc_value == $past(i_stack_top)
         && $stable(o_flags))
      else $error("literal return wrong");
   return_two_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_return |=> o_stack_pop ##1 !o_stack_pop && o_instr_ready)
      else $error("return timing wrong");
   rotate_right_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_rot_right && dest_file
         |=> o_file_wr.data == {$past(flags_ff.carry), $past(freg[7:1])}
         && o_flags.carry == $past(freg[0]))
      else $error("rotate right wrong");
   rotate_left_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_rot_left && !dest_file
         |=> o_working == {$past(freg[6:0]), $past(flags_ff.carry)}
         && !o_file_wr.we)
      else $error("rotate left wrong");
   sleep_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_sleep |=> o_watchdog_clear && o_timeout_flag && !o_powerdown_flag && o_sleeping)
      else $error("sleep entry wrong");
   sub_carry_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_sub_lit |=> o_flags.carry == ($past(lit) >= $past(w_ff))
         && o_working == $past(lit) - $past(w_ff))
      else $error("subtract carry wrong");
   dir_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_dir_load && ins[2:0] == DIR_LAST
         |=> o_pin_direction_register[23:16] == $past(w_ff))
      else $error("direction load wrong");
   nop_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      take && is_nop |=> o_pc_advance && !o_file_wr.we && $stable(o_working) && $stable(o_flags))
      else $error("no-op changed state");
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import exec_subset_pkg::*;
   // ==========================================
   // Stimulus and observed signals.
   logic i_ref_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_instr_valid = 1'b0;
   logic [13:0] i_instr = 14'h0000;
   logic [7:0] i_file_rdata = 8'h00;
   logic [12:0] i_stack_top = 13'h0000;
   logic i_wake = 1'b0;
   logic o_instr_ready, o_stack_pop, o_pc_load, o_pc_advance, o_watchdog_clear;
   logic o_timeout_flag, o_powerdown_flag, o_sleeping, o_unsupported;
   logic [6:0] o_file_raddr;
   logic [12:0] o_pc_value;
   logic [7:0] o_working, o_interrupt_control_reg, o_prescaler_cfg;
   logic [23:0] o_pin_direction_register;
   file_wr_s o_file_wr;
   alu_flags_s o_flags;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] ew = 8'h00;
   logic [2:0] ef = 3'h0;

   always #2 i_ref_clk = ~i_ref_clk;

   exec_subset i_dut (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_file_raddr(o_file_raddr),
      .i_file_rdata(i_file_rdata), .o_file_wr(o_file_wr), .i_stack_top(i_stack_top),
      .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
      .o_pc_advance(o_pc_advance), .o_working(o_working), .o_flags(o_flags),
      .o_interrupt_control_reg(o_interrupt_control_reg), .o_prescaler_cfg(o_prescaler_cfg),
      .o_pin_direction_register(o_pin_direction_register),
      .o_watchdog_clear(o_watchdog_clear), .o_timeout_flag(o_timeout_flag),
      .o_powerdown_flag(o_powerdown_flag), .o_sleeping(o_sleeping), .i_wake(i_wake),
      .o_unsupported(o_unsupported)
   );

   // ==========================================
   // Shared tasks.
   task automatic report_and_stop();
      if (errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic chk_wf(input string what);
      check({o_working, o_flags}, {ew, ef}, what);
   endtask

   // Valid is left high on return so that back-to-back words never toggle it in one step;
   // a word offered during the stall after a return is simply not taken yet.
   task automatic step(input logic [13:0] ins, input logic [7:0] rd);
      int n;
      n = 0;
      while (o_instr_ready !== 1'b1 && n < 20) begin
         @(negedge i_ref_clk);
         n++;
      end
      if (o_instr_ready !== 1'b1) begin
         errors++;
         $display("unexpected at %0t: instruction port never ready", $time);
      end
      i_instr_valid = 1'b1;
      i_instr = ins;
      i_file_rdata = rd;
      @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask

   task automatic setw(input logic [7:0] k);
      step({6'h34, k}, 8'h00);
      ew = k;
   endtask

   // ==========================================
   // Scenarios.
   task automatic reset_values();
      chk_wf("w reset");
      check({o_interrupt_control_reg, o_prescaler_cfg}, 16'h00FF, "cfg reset");
      check(o_pin_direction_register, 24'hFF_FFFF, "dir reset");
      check({o_timeout_flag, o_powerdown_flag, o_sleeping, o_instr_ready}, 4'hD, "pwr reset");
   endtask

   task automatic ret_tests();
      i_stack_top = 13'h1ABC;
      setw(8'hC3);
      check({o_stack_pop, o_pc_load, o_pc_value, o_instr_ready, o_working, o_flags},
         {2'b11, 13'h1ABC, 1'b0, ew, ef}, "literal return");
      i_stack_top = 13'h0123;
      step(14'h0008, 8'h00);
      check({o_stack_pop, o_pc_load, o_pc_value, o_instr_ready, o_working, o_flags}, {2'b11, 13'h0123, 1'b0, ew, ef}, "return");
      check(o_interrupt_control_reg[7], 1'b0, "ie early");
      i_stack_top = 13'h0F0F;
      step(14'h0009, 8'h00);
      check({o_stack_pop, o_pc_load, o_pc_value, o_instr_ready},
         {2'b11, 13'h0F0F, 1'b0}, "irq return");
      check(o_interrupt_control_reg[7], 1'b1, "ie set");
      i_instr_valid = 1'b0;
      @(negedge i_ref_clk);
      check({o_stack_pop, o_instr_ready}, 2'b01, "stall end");
   endtask

   task automatic move_tests();
      setw(8'h5A);
      step(14'h00C5, 8'h00);
      check({o_file_wr, o_pc_advance}, {1'b1, 7'h45, 8'h5A, 1'b1}, "store");
      chk_wf("store w");
      step(14'h0062, 8'h00);
      check(o_prescaler_cfg, 8'h5A, "prescaler");
      for (int i = 5; i < 8; i++) begin
         setw(8'h10 + 8'(i));
         step(14'h0060 | 14'(i), 8'h00);
      end
      step(14'h0064, 8'h00);
      check({o_prescaler_cfg, o_pin_direction_register}, 32'h5A17_1615, "direction");
   endtask

   task automatic rot_tests();
      step(14'h0C20, 8'hE6);
      ew = 8'h73;
      chk_wf("rot right w");
      step(14'h0D20, 8'hE6);
      ew = 8'hCC;
      ef = 3'b100;
      chk_wf("rot left w");
      step(14'h0CA0, 8'h01);
      check({o_file_raddr, o_file_wr, o_working, o_flags},
         {7'h20, 1'b1, 7'h20, 8'h80, ew, ef}, "rot right f");
      step(14'h0DA1, 8'h80);
      check({o_file_wr, o_working, o_flags}, {1'b1, 7'h21, 8'h01, ew, ef}, "rot left f");
   endtask

   task automatic logic_tests();
      setw(8'hB5);
      step(14'h3AAF, 8'h00);
      ew = 8'h1A;
      chk_wf("xor literal");
      step(14'h0690, 8'h1A);
      ef = 3'b101;
      check({o_file_wr, o_working, o_flags}, {1'b1, 7'h10, 8'h00, ew, ef}, "xor file");
      step(14'h0E20, 8'hA5);
      ew = 8'h5A;
      check({o_file_wr.we, o_working, o_flags}, {1'b0, ew, ef}, "swap w");
      step(14'h0EA0, 8'h3C);
      check({o_file_wr, o_working, o_flags}, {1'b1, 7'h20, 8'hC3, ew, ef}, "swap f");
   endtask

   task automatic sub_tests();
      for (int w = 1; w < 4; w++) begin
         setw(8'(w));
         step(14'h3C02, 8'h00);
         ew = 8'h02 - 8'(w);
         ef = {w <= 2, w <= 2, ew == 8'h00};
         chk_wf("sub literal");
      end
      setw(8'h02);
      step(14'h02A7, 8'h01);
      ef = 3'b000;
      check({o_file_wr, o_working, o_flags}, {1'b1, 7'h27, 8'hFF, ew, ef}, "sub file f");
      step(14'h0227, 8'h13);
      ew = 8'h11;
      ef = 3'b110;
      check({o_file_wr.we, o_working, o_flags}, {1'b0, ew, ef}, "sub file w");
   endtask

   task automatic nop_sleep();
      for (int i = 0; i < 4; i++) begin
         step(14'(i) << 5, 8'hFF);
         check({o_pc_advance, o_file_wr.we, o_stack_pop, o_unsupported, o_working, o_flags},
            {4'b1000, ew, ef}, "nop");
      end
      // An instruction outside the subset only advances the counter and is flagged.
      step(14'h3800, 8'h00);
      check({o_unsupported, o_pc_advance, o_file_wr.we, o_working, o_flags},
         {3'b110, ew, ef}, "undecoded");
      step(14'h0063, 8'h00);
      i_instr_valid = 1'b0;
      check({o_watchdog_clear, o_timeout_flag, o_powerdown_flag, o_sleeping, o_instr_ready,
         o_pc_advance}, 6'b110100, "sleep");
      repeat (3) @(negedge i_ref_clk);
      check({o_watchdog_clear, o_sleeping, o_instr_ready}, 3'b010, "asleep");
      i_wake = 1'b1;
      @(negedge i_ref_clk);
      i_wake = 1'b0;
      @(negedge i_ref_clk);
      check({o_sleeping, o_instr_ready}, 2'b01, "wake");
   endtask

   // ==========================================
   // Sequence and hang guard.
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (8) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      @(negedge i_ref_clk);
      reset_values();
      ret_tests();
      move_tests();
      rot_tests();
      logic_tests();
      sub_tests();
      nop_sleep();
      report_and_stop();
   end
endmodule
`default_nettype wire
